// ==== verilog/bbr_top.v ====
// Boot-time baud selection with escape-string recovery and host UART
// Contract
// [RQ1] After reset the port runs 9600 8N1 for exactly 750 ms.
// [RQ2] If the window ends with no escape, the stored line settings apply.
// [RQ3] An escape string with CR inside the window keeps 9600 8N1.
// [RQ4] An accepted escape loads factory defaults into all config registers.
// [RQ5] The baud rate comes from configuration registers 520 and 521.
// [RQ6] The divider gives exact rates whenever rate times 0.004096 is whole. The code is exact only when 20000000 divided by the rate is whole.
// [RQ7] Command mode exchanges plain text characters over the host port.
// [RQ8] Escape match is in order and restarts on any mismatching character.
`timescale 1ns/1ps
`include "bbr_defs.vh"
module bbr_top #(
  parameter WINDOW_CYC = (`BBR_CLK_HZ / 1000) * `BBR_WINDOW_MS,
  // Bit period of the safe rate; a smaller value only shortens simulation
  parameter [15:0] SAFE_DIV = `BBR_SAFE_DIV
) (
  input wire MCLK_IN,
  input wire NRST_IN,
  input wire RXD_IN,
  output reg TXD_OUT,
  input wire [7:0] CFG520_IN,
  input wire [7:0] CFG521_IN,
  input wire CFG_WE_IN,
  output reg [7:0] CFG520_OUT,
  output reg [7:0] CFG521_OUT,
  output reg FACTORY_LOAD_OUT,
  output reg SAFE_MODE_OUT,
  output reg [7:0] RX_DATA_OUT,
  output reg RX_VALID_OUT,
  input wire RX_READY_IN,
  input wire [7:0] TX_DATA_IN,
  input wire TX_VALID_IN,
  output reg TX_READY_OUT
);
  reg [1:0] state;
  reg [31:0] win_cnt;
  reg [15:0] div;
  reg [15:0] rx_tick;
  reg [3:0] rx_bit;
  reg [7:0] rx_sh;
  reg rx_busy;
  reg rx_s1;
  reg rx_s2;
  reg [7:0] rx_byte;
  reg rx_stb;
  reg [3:0] esc_idx;
  reg [15:0] tx_tick;
  reg [3:0] tx_bit;
  reg [9:0] tx_sh;
  reg tx_busy;
  wire [7:0] buf_data;
  wire buf_valid;
  wire buf_ready;
  wire buf_sready;
  wire [7:0] esc_chr;
  wire [63:0] esc_str;
  wire [15:0] half_div;

  // Receive bytes pass a two-entry buffer; a byte arriving while it is full is dropped
  bbr_buf2 #(.W(8)) u_rxbuf (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .s_data_in(rx_byte),
    .s_valid_in(rx_stb),
    .s_ready_out(buf_sready),
    .m_data_out(buf_data),
    .m_valid_out(buf_valid),
    .m_ready_in(buf_ready)
  );

  // Output register takes a new byte when empty or being drained
  assign buf_ready = ~RX_VALID_OUT | RX_READY_IN;
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      RX_VALID_OUT <= 1'b0;
      RX_DATA_OUT <= 8'h00;
    end
    else if (buf_ready)
    begin
      RX_VALID_OUT <= buf_valid; // [RQ7]
      RX_DATA_OUT <= buf_data;
    end
  end

  // Divider: 16-bit cycles per bit; registers are high and low bytes
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      div <= SAFE_DIV;
    else if (state == `BBR_ST_USER)
      div <= ({CFG521_OUT, CFG520_OUT} < 16'h0004) ?
        16'h0004 : {CFG521_OUT, CFG520_OUT}; // [RQ5] [RQ6] [RQ2]
    else
      div <= SAFE_DIV; // [RQ1] [RQ3]
  end
  assign half_div = {1'b0, div[15:1]};

  // Boot window and mode selection
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      state <= `BBR_ST_SAFE;
      win_cnt <= 32'h0;
      SAFE_MODE_OUT <= 1'b1;
    end
    else
    begin
      case (state)
        `BBR_ST_SAFE:
        begin
          win_cnt <= win_cnt + 32'h1;
          if (rx_stb && rx_byte == `BBR_CR && esc_idx == 4'h8)
            state <= `BBR_ST_RECOV; // [RQ3]
          else if (win_cnt == WINDOW_CYC - 1)
          begin
            state <= `BBR_ST_USER; // [RQ1] [RQ2]
            SAFE_MODE_OUT <= 1'b0;
          end
        end
        `BBR_ST_RECOV:
          SAFE_MODE_OUT <= 1'b1; // [RQ3]
        `BBR_ST_USER:
          SAFE_MODE_OUT <= 1'b0;
        default:
          state <= `BBR_ST_SAFE;
      endcase
    end
  end

  // Escape matcher; a mismatch may itself start a new match
  assign esc_str = `BBR_ESC_STR;
  assign esc_chr = esc_str[{3'h7 - esc_idx[2:0], 3'h0} +: 8];
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      esc_idx <= 4'h0;
    else if (rx_stb && state == `BBR_ST_SAFE)
    begin
      if (esc_idx < 4'h8 && rx_byte == esc_chr)
        esc_idx <= esc_idx + 4'h1; // [RQ8]
      else if (rx_byte == 8'h21)
        esc_idx <= 4'h1; // [RQ8]
      else
        esc_idx <= 4'h0; // [RQ8]
    end
  end

  // Config registers; factory load wins over a software write
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      CFG520_OUT <= `BBR_DEF_BAUD520;
      CFG521_OUT <= `BBR_DEF_BAUD521;
      FACTORY_LOAD_OUT <= 1'b0;
    end
    else
    begin
      FACTORY_LOAD_OUT <= 1'b0;
      if (state == `BBR_ST_SAFE && rx_stb && rx_byte == `BBR_CR &&
          esc_idx == 4'h8)
      begin
        CFG520_OUT <= `BBR_DEF_BAUD520; // [RQ4]
        CFG521_OUT <= `BBR_DEF_BAUD521; // [RQ4]
        FACTORY_LOAD_OUT <= 1'b1; // [RQ4]
      end
      else if (CFG_WE_IN)
      begin
        CFG520_OUT <= CFG520_IN; // [RQ5]
        CFG521_OUT <= CFG521_IN; // [RQ5]
      end
    end
  end

  // Receiver 8N1, mid-bit sampling; byte dropped if stop bit low or buffer full
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_busy <= 1'b0;
      rx_tick <= 16'h0;
      rx_bit <= 4'h0;
      rx_sh <= 8'h00;
      rx_byte <= 8'h00;
      rx_stb <= 1'b0;
    end
    else
    begin
      rx_s1 <= RXD_IN;
      rx_s2 <= rx_s1;
      rx_stb <= 1'b0;
      if (!rx_busy)
      begin
        if (!rx_s2)
        begin
          rx_busy <= 1'b1;
          rx_tick <= half_div;
          rx_bit <= 4'h0;
        end
      end
      else if (rx_tick != 16'h0)
        rx_tick <= rx_tick - 16'h1;
      else
      begin
        rx_tick <= div - 16'h1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_s2)
          rx_busy <= 1'b0; // False start
        else if (rx_bit == 4'h9)
        begin
          rx_busy <= 1'b0;
          rx_byte <= rx_sh;
          rx_stb <= rx_s2 & buf_sready; // Stop bit must be high
        end
        else if (rx_bit != 4'h0)
          rx_sh <= {rx_s2, rx_sh[7:1]};
      end
    end
  end

  // Transmitter 8N1, LSB first; line idles high
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
    begin
      TXD_OUT <= 1'b1;
      TX_READY_OUT <= 1'b0;
      tx_busy <= 1'b0;
      tx_tick <= 16'h0;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
    end
    else if (!tx_busy)
    begin
      TX_READY_OUT <= 1'b1;
      if (TX_VALID_IN && TX_READY_OUT)
      begin
        tx_busy <= 1'b1;
        TX_READY_OUT <= 1'b0;
        tx_sh <= {1'b1, TX_DATA_IN, 1'b0}; // [RQ7]
        tx_tick <= div - 16'h1;
        tx_bit <= 4'h0;
        TXD_OUT <= 1'b0;
      end
    end
    else if (tx_tick != 16'h0)
      tx_tick <= tx_tick - 16'h1;
    else
    begin
      tx_tick <= div - 16'h1;
      if (tx_bit == 4'h9)
      begin
        tx_busy <= 1'b0;
        TXD_OUT <= 1'b1;
      end
      else
      begin
        tx_bit <= tx_bit + 4'h1;
        TXD_OUT <= tx_sh[tx_bit + 4'h1];
      end
    end
  end
endmodule

// ==== verilog/bbr_defs.vh ====
// Constants for the boot baud recovery block
`ifndef BBR_DEFS_VH
`define BBR_DEFS_VH
`define BBR_CLK_HZ 20000000
`define BBR_SAFE_BAUD 9600
`define BBR_WINDOW_MS 750
`define BBR_SAFE_DIV 16'h0823
`define BBR_DEF_BAUD520 8'h00
`define BBR_DEF_BAUD521 8'h00
`define BBR_CR 8'h0D
`define BBR_ESC_LEN 8
`define BBR_ESC_STR 64'h213C4249534D3E21
`define BBR_ST_SAFE 2'h0
`define BBR_ST_RECOV 2'h1
`define BBR_ST_USER 2'h2
`endif

// ==== verilog/bbr_buf2.v ====
// Two-entry valid/ready buffer for one byte stream
`timescale 1ns/1ps
module bbr_buf2 #(
  parameter W = 8
) (
  input wire clk_in,
  input wire nrst_in,
  input wire [W-1:0] s_data_in,
  input wire s_valid_in,
  output wire s_ready_out,
  output wire [W-1:0] m_data_out,
  output wire m_valid_out,
  input wire m_ready_in
);
  reg [W-1:0] mem0;
  reg [W-1:0] mem1;
  reg [1:0] cnt;
  wire push;
  wire pop;
  // Ready while not full, so a stalled drain backs up to the source
  assign s_ready_out = (cnt != 2'h2);
  assign m_valid_out = (cnt != 2'h0);
  assign m_data_out = mem0;
  assign push = s_valid_in & s_ready_out;
  assign pop = m_valid_out & m_ready_in;
  // Entry 0 is always the head
  always @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      cnt <= 2'h0;
      mem0 <= {W{1'b0}};
      mem1 <= {W{1'b0}};
    end
    else
    begin
      if (pop)
      begin
        mem0 <= (cnt == 2'h2) ? mem1 : s_data_in;
        if (cnt == 2'h2 && push)
          mem1 <= s_data_in;
      end
      else if (push)
      begin
        if (cnt == 2'h0)
          mem0 <= s_data_in;
        else
          mem1 <= s_data_in;
      end
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== testbench/bbr_host.sv ====
// Host serial port model: 8N1 sender and receiver
`timescale 1ns/1ps
module bbr_host (
  input wire clk_in,
  output reg rxd_out,
  input wire txd_in
);
  initial rxd_out = 1'b1;
  // Frame goes LSB first; the line is left high after the stop bit
  task send(input [7:0] d, input integer div);
    reg [9:0] f;
    integer i;
    begin
      f = {1'b1, d, 1'b0};
      for (i = 0; i < 10; i = i + 1)
      begin
        @(negedge clk_in);
        rxd_out <= f[i];
        repeat (div - 1) @(negedge clk_in);
      end
    end
  endtask
  // Samples mid-bit, so a wrong divider smears the byte
  task recv(output [7:0] d, input integer div);
    integer i;
    begin
      @(negedge txd_in);
      repeat (div / 2) @(posedge clk_in);
      for (i = 0; i < 8; i = i + 1)
      begin
        repeat (div) @(posedge clk_in);
        d[i] = txd_in;
      end
    end
  endtask
endmodule

// ==== testbench/bbr_props.sv ====
// Port checker for boot baud recovery
`timescale 1ns/1ps
`include "bbr_defs.vh"
module bbr_props #(
  parameter WINDOW_CYC = 15000000
) (
  input wire MCLK_IN,
  input wire NRST_IN,
  input wire TXD_OUT,
  input wire [7:0] CFG520_IN,
  input wire [7:0] CFG521_IN,
  input wire CFG_WE_IN,
  input wire [7:0] CFG520_OUT,
  input wire [7:0] CFG521_OUT,
  input wire FACTORY_LOAD_OUT,
  input wire SAFE_MODE_OUT,
  input wire [7:0] RX_DATA_OUT,
  input wire RX_VALID_OUT,
  input wire RX_READY_IN,
  input wire TX_VALID_IN,
  input wire TX_READY_OUT
);
  integer cnt;
  reg recov;
  // Cycles since reset release, saturating just past the window
  always @(posedge MCLK_IN)
  begin
    if (!NRST_IN)
      cnt <= 0;
    else if (cnt < WINDOW_CYC + 8)
      cnt <= cnt + 1;
    recov <= NRST_IN && (recov || FACTORY_LOAD_OUT);
  end
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  sequence s_tx_go;
    TX_VALID_IN && TX_READY_OUT;
  endsequence
  sequence s_start;
    !TXD_OUT && !TX_READY_OUT ##1 (!TXD_OUT) [*3];
  endsequence
  // Safe rate holds for exactly the window, then drops unless recovered
  a_safe_early: assert property (cnt < WINDOW_CYC |-> SAFE_MODE_OUT)
    else $error("safe rate left early");
  a_window_end: assert property (
    cnt == WINDOW_CYC && !recov && !FACTORY_LOAD_OUT |-> !SAFE_MODE_OUT)
    else $error("stored rate not taken");
  a_recov_keep: assert property (recov |-> SAFE_MODE_OUT)
    else $error("safe rate lost after recovery");
  a_esc_window: assert property (
    FACTORY_LOAD_OUT |-> SAFE_MODE_OUT && cnt <= WINDOW_CYC)
    else $error("late recovery");
  a_fl_dflt: assert property (
    FACTORY_LOAD_OUT |-> CFG520_OUT == `BBR_DEF_BAUD520
    && CFG521_OUT == `BBR_DEF_BAUD521)
    else $error("defaults not loaded");
  a_fl_pulse: assert property (
    FACTORY_LOAD_OUT |=> !FACTORY_LOAD_OUT)
    else $error("load pulse too long");
  a_cfg_write: assert property (
    CFG_WE_IN |=> FACTORY_LOAD_OUT
    || (CFG520_OUT == $past(CFG520_IN) && CFG521_OUT == $past(CFG521_IN)))
    else $error("config write lost");
  a_tx_start: assert property (s_tx_go |=> s_start)
    else $error("start bit wrong");
  a_rx_hold: assert property (
    RX_VALID_OUT && !RX_READY_IN |=> RX_VALID_OUT && $stable(RX_DATA_OUT))
    else $error("rx byte dropped");
endmodule
bind bbr_top bbr_props #(.WINDOW_CYC(WINDOW_CYC)) u_props (
  .MCLK_IN(MCLK_IN),
  .NRST_IN(NRST_IN),
  .TXD_OUT(TXD_OUT),
  .CFG520_IN(CFG520_IN),
  .CFG521_IN(CFG521_IN),
  .CFG_WE_IN(CFG_WE_IN),
  .CFG520_OUT(CFG520_OUT),
  .CFG521_OUT(CFG521_OUT),
  .FACTORY_LOAD_OUT(FACTORY_LOAD_OUT),
  .SAFE_MODE_OUT(SAFE_MODE_OUT),
  .RX_DATA_OUT(RX_DATA_OUT),
  .RX_VALID_OUT(RX_VALID_OUT),
  .RX_READY_IN(RX_READY_IN),
  .TX_VALID_IN(TX_VALID_IN),
  .TX_READY_OUT(TX_READY_OUT)
);

// ==== testbench/tb_bbr_top.sv ====
// Testbench for boot baud recovery
`timescale 1ns/1ps
`include "bbr_defs.vh"
module tb_bbr_top;
  // Short window and safe divider keep the run brief
  localparam WIN = 20000;
  localparam [15:0] SDIV = 16'h0040;
  localparam LIMIT = 60000;
  reg clk = 0, nrst = 0, tx_v = 0, we = 0, rdy = 1, flseen = 0;
  reg [7:0] c0 = 8'h00, c1 = 8'h00, tx_d = 8'h00, b;
  reg [31:0] seed = 32'h45B0;
  reg [31:0] dseed = 32'h45B0;
  reg [63:0] esc = `BBR_ESC_STR;
  wire rxd, txd, fl, safe, rv, tr;
  wire [7:0] o0, o1, rd;
  integer bad_count = 0, compares = 0, cyc = 0, i;
  reg [7:0] q[$];
  reg [7:0] m[$];
  bbr_top #(.WINDOW_CYC(WIN), .SAFE_DIV(SDIV)) u_dut (.MCLK_IN(clk),
    .NRST_IN(nrst),
    .RXD_IN(rxd), .TXD_OUT(txd), .CFG520_IN(c0), .CFG521_IN(c1),
    .CFG_WE_IN(we), .CFG520_OUT(o0), .CFG521_OUT(o1),
    .FACTORY_LOAD_OUT(fl), .SAFE_MODE_OUT(safe), .RX_DATA_OUT(rd),
    .RX_VALID_OUT(rv), .RX_READY_IN(rdy), .TX_DATA_IN(tx_d),
    .TX_VALID_IN(tx_v), .TX_READY_OUT(tr));
  bbr_host u_host (.clk_in(clk), .rxd_out(rxd), .txd_in(txd));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task cfg(input [7:0] a, input [7:0] h);
    begin
      @(negedge clk);
      c0 <= a;
      c1 <= h;
      we <= 1'b1;
      @(negedge clk);
      we <= 1'b0;
      chk(o0, a);
      chk(o1, h);
    end
  endtask
  // Request held until ready is seen high before the taking edge
  task tx_byte(input [7:0] d, input integer div);
    begin
      fork
        u_host.recv(b, div);
        begin
          @(negedge clk);
          tx_d <= d;
          tx_v <= 1'b1;
          while (!tr) @(negedge clk);
          @(negedge clk);
          tx_v <= 1'b0;
        end
      join
      chk(b, d);
    end
  endtask
  initial forever #25 clk = ~clk;
  // Cycle count for the ceiling; load pulse capture clears with reset
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    flseen <= nrst & (flseen | fl);
  end
  // Random consumer stalls; a byte is logged when the next edge takes it
  always @(negedge clk)
  begin
    seed = xs(seed);
    rdy = seed[0] | seed[1];
    if (rv && rdy)
      q.push_back(rd);
  end
  // Tests race a cycle ceiling; either way the run ends in wrap_up
  initial
  begin
    fork
      begin
        while (cyc < LIMIT) @(posedge clk);
        bad_count = bad_count + 1;
        $display("timeout at cycle %0d", cyc);
      end
      begin
        repeat (8) @(negedge clk);
        nrst <= 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h00, safe}, 8'h01);
        dseed = xs(dseed);
        tx_byte(dseed[7:0], SDIV);
        cfg(dseed[15:8], 8'h5A);
        chk({7'h00, flseen}, 8'h00);
        $display("test safe rate done");
        // Stray byte and doubled opener force the match to restart
        u_host.send(8'h78, SDIV);
        u_host.send(8'h21, SDIV);
        for (i = 7; i >= 0; i = i - 1)
          u_host.send(esc[i * 8 +: 8], SDIV);
        u_host.send(`BBR_CR, SDIV);
        repeat (10) @(negedge clk);
        chk({7'h00, flseen}, 8'h01);
        chk(o0, `BBR_DEF_BAUD520);
        chk(o1, `BBR_DEF_BAUD521);
        while (cyc < WIN + 200) @(negedge clk);
        chk({7'h00, safe}, 8'h01);
        $display("test recovery done");
        nrst <= 1'b0;
        repeat (8) @(negedge clk);
        nrst <= 1'b1;
        repeat (2) @(negedge clk);
        cfg(8'h10, 8'h00);
        repeat (WIN) @(negedge clk);
        chk({7'h00, safe}, 8'h00);
        dseed = xs(dseed);
        tx_byte(dseed[23:16], 16);
        q.delete();
        for (i = 0; i < 3; i = i + 1)
        begin
          dseed = xs(dseed);
          m.push_back(dseed[7:0]);
          u_host.send(dseed[7:0], 16);
        end
        repeat (200) @(negedge clk);
        chk(8'(q.size()), 8'h03);
        for (i = 0; i < 3; i = i + 1)
          chk(q[i], m[i]);
        $display("test stored rate done");
      end
    join_any
    wrap_up;
  end
endmodule
